// ==== include/selfid_pkg.sv ====
// shared constants and carrier types for the self-id and upper mask block
package selfid_pkg;

  // register byte offsets
  localparam logic [7:0] MASK_SET_OFFSET = 8'h70;
  localparam logic [7:0] MASK_CLEAR_OFFSET = 8'h74;
  localparam logic [7:0] TALLY_OFFSET = 8'h90;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h94;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h98;

  // self-id tally field positions
  localparam int FAULT_BIT = 31;
  localparam int GEN_LSB = 16;
  localparam int GEN_MSB = 23;
  localparam int COUNT_LSB = 2;
  localparam int COUNT_MSB = 10;
  localparam int GEN_WIDTH = GEN_MSB - GEN_LSB + 1;
  localparam int COUNT_WIDTH = COUNT_MSB - COUNT_LSB + 1;

  // reset values and quadlet count ceiling
  localparam logic [GEN_WIDTH-1:0] GEN_RESET = 8'h00;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 9'h000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 9'h1FF;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // channel split: upper mask covers 32..63
  localparam logic [5:0] UPPER_CHANNEL_BASE = 6'h20;

  // interrupt status bit positions
  localparam int IRQ_BITS = 4;
  localparam int IRQ_BUS_RESET = 0;
  localparam int IRQ_SELF_ID_DONE = 1;
  localparam int IRQ_SELF_ID_FAULT = 2;
  localparam int IRQ_ISO_DROP = 3;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET = 4'h0;

  // self-id reception progress
  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_ACTIVE = 1'b1
  } self_id_state_e;

  // events from the link receive path
  typedef struct packed {
    logic bus_reset;
    logic rx_start;
    logic quadlet_written;
    logic hw_error;
    logic write_error;
    logic rx_done;
  } self_id_event_s;

  // isochronous packet header seen by the receive path
  typedef struct packed {
    logic valid;
    logic [5:0] channel;
  } iso_header_s;

endpackage

// ==== src/iso_channel_filter.sv ====
// per-packet accept or drop decision for isochronous receive channels
`timescale 1ns/1ps

module iso_channel_filter (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] upper_mask_in,
  input wire selfid_pkg::iso_header_s header_in,
  output logic accept_out,
  output logic drop_out
);

  // true when channel is in the upper half and its enable bit is off
  function automatic logic upper_blocked(input logic [5:0] ch,
                                         input logic [31:0] mask);
    logic [4:0] idx;
    idx = ch[4:0];
    upper_blocked = (ch >= selfid_pkg::UPPER_CHANNEL_BASE) && !mask[idx];
  endfunction

  // registered decision; lower channels pass, their mask lives elsewhere
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accept_out <= 1'b0;
      drop_out <= 1'b0;
    end else begin
      accept_out <= header_in.valid &&
        !upper_blocked(header_in.channel, upper_mask_in); // RULE12
      drop_out <= header_in.valid &&
        upper_blocked(header_in.channel, upper_mask_in); // RULE14
    end
  end

  property p_drop_blocked;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (header_in.valid && header_in.channel[5] &&
     !upper_mask_in[header_in.channel[4:0]])
    |=> (drop_out && !accept_out);
  endproperty
  a_drop_blocked: assert property (p_drop_blocked) // RULE14
    else $error("blocked upper channel packet not dropped");

  property p_accept_enabled;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (header_in.valid && header_in.channel[5] &&
     upper_mask_in[header_in.channel[4:0]])
    |=> (accept_out && !drop_out);
  endproperty
  a_accept_enabled: assert property (p_accept_enabled) // RULE12
    else $error("enabled upper channel packet not accepted");

endmodule

// ==== src/self_id_regs.sv ====
// self-id tally, upper isochronous receive mask and interrupt registers
`timescale 1ns/1ps

// What this block does
// RULE1: set fault flag bit 31 on any error in latest self-id reception
// RULE2: clear fault flag when a later reception ends with no error
// RULE3: hardware faults and host memory write failures both count as errors
// RULE4: tally bits 30-24, 15-11 and 1-0 read as zero
// RULE5: generation field bits 23-16 increments on each bus reset
// RULE6: generation wraps from 255 to zero
// RULE7: bits 10-2 hold quadlets written to buffer this generation
// RULE8: quadlet count includes header quadlet and all self-id quadlets
// RULE9: quadlet count clears to zero when a new reception starts
// RULE10: 32-bit mask enables isochronous receive on upper 32 channels
// RULE11: reads at set or clear address return current mask
// RULE12: mask bit n enables channel n plus 32
// RULE13: ones written at set address set bits, at clear address clear
// RULE14: packets on channels 32-63 with mask bit zero are dropped
module self_id_regs (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire selfid_pkg::self_id_event_s self_id_event_in,
  input wire selfid_pkg::iso_header_s iso_header_in,
  output logic iso_accept_out,
  output logic iso_drop_out,
  output logic irq_out
);

  selfid_pkg::self_id_state_e state_q;
  selfid_pkg::self_id_state_e state_d;
  logic self_id_fault_flag_q;
  logic fault_seen_q;
  logic [selfid_pkg::GEN_WIDTH-1:0] bus_reset_generation_count_q;
  logic [selfid_pkg::COUNT_WIDTH-1:0] self_id_quadlet_count_q;
  logic [31:0] upper_channel_rx_enable_bit_q;
  logic [selfid_pkg::IRQ_BITS-1:0] irq_status_q;
  logic [selfid_pkg::IRQ_BITS-1:0] irq_mask_q;
  logic [selfid_pkg::IRQ_BITS-1:0] irq_event;
  logic any_error;
  logic rx_active;
  logic rx_finish;
  logic [31:0] tally_word;
  logic wr_mask_set;
  logic wr_mask_clear;
  logic wr_irq_status;
  logic wr_irq_mask;

  // write decode shared by the mask and interrupt register processes
  assign wr_mask_set = reg_wr_in &&
    (reg_addr_in == selfid_pkg::MASK_SET_OFFSET);
  assign wr_mask_clear = reg_wr_in &&
    (reg_addr_in == selfid_pkg::MASK_CLEAR_OFFSET);
  assign wr_irq_status = reg_wr_in &&
    (reg_addr_in == selfid_pkg::IRQ_STATUS_OFFSET);
  assign wr_irq_mask = reg_wr_in &&
    (reg_addr_in == selfid_pkg::IRQ_MASK_OFFSET);

  // both error sources feed the same fault path
  assign any_error = self_id_event_in.hw_error ||
    self_id_event_in.write_error; // RULE3
  assign rx_active = (state_q == selfid_pkg::RX_ACTIVE);
  assign rx_finish = rx_active && self_id_event_in.rx_done;

  // reception tracker: a start always reopens, even mid-reception
  always_comb begin
    state_d = state_q;
    case (state_q)
      selfid_pkg::RX_IDLE: begin
        if (self_id_event_in.rx_start) begin
          state_d = selfid_pkg::RX_ACTIVE;
        end
      end
      selfid_pkg::RX_ACTIVE: begin
        if (self_id_event_in.rx_start) begin
          state_d = selfid_pkg::RX_ACTIVE;
        end else if (self_id_event_in.rx_done) begin
          state_d = selfid_pkg::RX_IDLE;
        end
      end
      default: begin
        state_d = selfid_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= selfid_pkg::RX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // per-reception error memory, used to decide the clear at the end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_seen_q <= 1'b0;
    end else if (self_id_event_in.rx_start) begin
      fault_seen_q <= any_error;
    end else if (rx_active && any_error) begin
      fault_seen_q <= 1'b1;
    end
  end

  // fault flag: an error sets it at once; a clean finish clears it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      self_id_fault_flag_q <= 1'b0;
    end else if ((rx_active || self_id_event_in.rx_start) && any_error) begin
      self_id_fault_flag_q <= 1'b1; // RULE1
    end else if (rx_finish && !fault_seen_q) begin
      self_id_fault_flag_q <= 1'b0; // RULE2
    end
  end

  // generation counter; natural 8-bit overflow gives the wrap
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_reset_generation_count_q <= selfid_pkg::GEN_RESET;
    end else if (self_id_event_in.bus_reset) begin
      bus_reset_generation_count_q <=
        bus_reset_generation_count_q + 8'h01; // RULE5 RULE6
    end
  end

  // quadlet count; saturates so a runaway phy cannot alias to small
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      self_id_quadlet_count_q <= selfid_pkg::COUNT_RESET;
    end else if (self_id_event_in.rx_start) begin
      self_id_quadlet_count_q <= selfid_pkg::COUNT_RESET; // RULE9
    end else if (rx_active && self_id_event_in.quadlet_written &&
                 self_id_quadlet_count_q != selfid_pkg::COUNT_MAX) begin
      // header and data quadlets alike arrive as quadlet_written
      self_id_quadlet_count_q <=
        self_id_quadlet_count_q + 9'h001; // RULE7 RULE8
    end
  end

  // upper channel mask, set and clear through separate addresses
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      upper_channel_rx_enable_bit_q <= selfid_pkg::MASK_RESET;
    end else if (wr_mask_set) begin
      upper_channel_rx_enable_bit_q <=
        upper_channel_rx_enable_bit_q | reg_wdata_in; // RULE10 RULE13
    end else if (wr_mask_clear) begin
      upper_channel_rx_enable_bit_q <=
        upper_channel_rx_enable_bit_q & ~reg_wdata_in; // RULE13
    end
  end

  // packet filter keyed by the mask
  iso_channel_filter u_filter (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .upper_mask_in(upper_channel_rx_enable_bit_q),
    .header_in(iso_header_in),
    .accept_out(iso_accept_out),
    .drop_out(iso_drop_out)
  );

  // event sources for the interrupt status
  assign irq_event[selfid_pkg::IRQ_BUS_RESET] = self_id_event_in.bus_reset;
  assign irq_event[selfid_pkg::IRQ_SELF_ID_DONE] = rx_finish;
  assign irq_event[selfid_pkg::IRQ_SELF_ID_FAULT] =
    (rx_active || self_id_event_in.rx_start) && any_error;
  assign irq_event[selfid_pkg::IRQ_ISO_DROP] = iso_drop_out;

  // sticky status bits; a new event beats a write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < selfid_pkg::IRQ_BITS; gi++) begin : g_irq
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_status_q[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_status_q[gi] <= 1'b1;
        end else if (wr_irq_status && reg_wdata_in[gi]) begin
          irq_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt mask, plain read/write
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= selfid_pkg::IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_q <= reg_wdata_in[selfid_pkg::IRQ_BITS-1:0];
    end
  end

  // level interrupt, combinational from registered state
  assign irq_out = |(irq_status_q & irq_mask_q);

  // tally word; unused bit ranges stay zero
  always_comb begin
    tally_word = selfid_pkg::READ_IDLE; // RULE4
    tally_word[selfid_pkg::FAULT_BIT] = self_id_fault_flag_q;
    tally_word[selfid_pkg::GEN_MSB:selfid_pkg::GEN_LSB] =
      bus_reset_generation_count_q;
    tally_word[selfid_pkg::COUNT_MSB:selfid_pkg::COUNT_LSB] =
      self_id_quadlet_count_q;
  end

  // read data one cycle after the strobe, zero otherwise and unmapped
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= selfid_pkg::READ_IDLE;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        selfid_pkg::MASK_SET_OFFSET,
        selfid_pkg::MASK_CLEAR_OFFSET: begin
          reg_rdata_out <= upper_channel_rx_enable_bit_q; // RULE11
        end
        selfid_pkg::TALLY_OFFSET: begin
          reg_rdata_out <= tally_word;
        end
        selfid_pkg::IRQ_STATUS_OFFSET: begin
          reg_rdata_out <= {28'h0000000, irq_status_q};
        end
        selfid_pkg::IRQ_MASK_OFFSET: begin
          reg_rdata_out <= {28'h0000000, irq_mask_q};
        end
        default: begin
          reg_rdata_out <= selfid_pkg::READ_IDLE;
        end
      endcase
    end else begin
      reg_rdata_out <= selfid_pkg::READ_IDLE;
    end
  end

  // ---- checks kept beside the logic ----
  sequence s_error_in_rx;
    (rx_active || self_id_event_in.rx_start) && any_error;
  endsequence

  sequence s_clean_finish;
    rx_finish && !fault_seen_q && !any_error;
  endsequence

  property p_fault_set;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_error_in_rx |=> self_id_fault_flag_q;
  endproperty
  a_fault_set: assert property (p_fault_set) // RULE1
    else $error("fault flag not set after self-id error");

  property p_fault_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_clean_finish |=> !self_id_fault_flag_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear) // RULE2
    else $error("fault flag not cleared after clean reception");

  property p_write_error_counts;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rx_active && self_id_event_in.write_error && !self_id_event_in.rx_start)
    ##1 (rx_finish && !any_error) |=> self_id_fault_flag_q;
  endproperty
  a_write_error_counts: assert property (p_write_error_counts) // RULE3
    else $error("host write error did not hold the fault flag");

  property p_tally_reserved;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == selfid_pkg::TALLY_OFFSET)
    |=> (reg_rdata_out[30:24] == 7'h00 && reg_rdata_out[15:11] == 5'h00 &&
         reg_rdata_out[1:0] == 2'h0);
  endproperty
  a_tally_reserved: assert property (p_tally_reserved) // RULE4
    else $error("reserved tally bits read nonzero");

  property p_gen_step;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    self_id_event_in.bus_reset |=> bus_reset_generation_count_q ==
      8'($past(bus_reset_generation_count_q) + 8'h01);
  endproperty
  a_gen_step: assert property (p_gen_step) // RULE5
    else $error("generation did not step on bus reset");

  property p_gen_wrap;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (self_id_event_in.bus_reset && bus_reset_generation_count_q == 8'hFF)
    |=> bus_reset_generation_count_q == 8'h00;
  endproperty
  a_gen_wrap: assert property (p_gen_wrap) // RULE6
    else $error("generation did not wrap to zero");

  property p_count_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    self_id_event_in.rx_start |=> self_id_quadlet_count_q == 9'h000;
  endproperty
  a_count_clear: assert property (p_count_clear) // RULE9
    else $error("quadlet count not cleared at reception start");

  property p_count_step;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (rx_active && self_id_event_in.quadlet_written &&
     !self_id_event_in.rx_start && self_id_quadlet_count_q != 9'h1FF)
    |=> self_id_quadlet_count_q ==
      9'($past(self_id_quadlet_count_q) + 9'h001);
  endproperty
  a_count_step: assert property (p_count_step) // RULE7
    else $error("quadlet count did not advance");

  property p_mask_set;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_mask_set |=> upper_channel_rx_enable_bit_q ==
      ($past(upper_channel_rx_enable_bit_q) | $past(reg_wdata_in));
  endproperty
  a_mask_set: assert property (p_mask_set) // RULE13
    else $error("mask set write wrong");

  property p_mask_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_mask_clear |=> upper_channel_rx_enable_bit_q ==
      ($past(upper_channel_rx_enable_bit_q) & ~$past(reg_wdata_in));
  endproperty
  a_mask_clear: assert property (p_mask_clear) // RULE13
    else $error("mask clear write wrong");

  property p_mask_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && (reg_addr_in == selfid_pkg::MASK_SET_OFFSET ||
                   reg_addr_in == selfid_pkg::MASK_CLEAR_OFFSET))
    |=> reg_rdata_out == $past(upper_channel_rx_enable_bit_q);
  endproperty
  a_mask_read: assert property (p_mask_read) // RULE11
    else $error("mask read returned wrong value");

endmodule

// ==== dv/self_id_source.sv ====
// far-side model: link receive path feeding self-id events and iso headers
`timescale 1ns/1ps

module self_id_source (
  input wire logic sys_clk_in,
  output selfid_pkg::self_id_event_s event_out,
  output selfid_pkg::iso_header_s header_out
);
  selfid_pkg::self_id_event_s ev;

  // quiet at time zero: no event pulses, no header
  initial begin
    event_out = '0;
    header_out = '0;
  end

  // one bus reset pulse, one cycle long
  task automatic bus_reset();
    ev = '0;
    ev.bus_reset = 1'b1;
    @(posedge sys_clk_in) event_out <= ev;
    @(posedge sys_clk_in) event_out <= '0;
  endtask

  // start, header plus self-id quadlets one a cycle, then done;
  // err_at picks the quadlet that carries a fault, hw picks its kind
  task automatic reception(input int quads, input int err_at, input bit hw);
    ev = '0;
    ev.rx_start = 1'b1;
    @(posedge sys_clk_in) event_out <= ev;
    for (int i = 0; i < quads; i++) begin
      ev = '0;
      ev.quadlet_written = 1'b1;
      ev.hw_error = (i == err_at) && hw;
      ev.write_error = (i == err_at) && !hw;
      @(posedge sys_clk_in) event_out <= ev;
    end
    ev = '0;
    ev.rx_done = 1'b1;
    @(posedge sys_clk_in) event_out <= ev;
    @(posedge sys_clk_in) event_out <= '0;
  endtask

  // one header; channel lines flip afterwards so a stale value never helps
  task automatic send_header(input logic [5:0] ch);
    @(posedge sys_clk_in) header_out <= '{1'b1, ch};
    @(posedge sys_clk_in) header_out <= '{1'b0, ~ch};
  endtask
endmodule

// ==== dv/self_id_regs_bench.sv ====
// self-checking bench for the self-id tally, upper mask and interrupts
`timescale 1ns/1ps

module self_id_regs_bench;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  selfid_pkg::self_id_event_s self_id_event_in;
  selfid_pkg::iso_header_s iso_header_in;
  logic iso_accept_out;
  logic iso_drop_out;
  logic irq_out;
  int errors = 0;
  int check_count = 0;
  logic [31:0] rd_val;
  logic [31:0] mask_exp;
  logic [7:0] gen_exp = 8'h00;

  // 40 MHz clock
  always #12.5 sys_clk_in = ~sys_clk_in;

  self_id_regs uut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .self_id_event_in(self_id_event_in),
    .iso_header_in(iso_header_in), .iso_accept_out(iso_accept_out),
    .iso_drop_out(iso_drop_out), .irq_out(irq_out)
  );

  self_id_source src (
    .sys_clk_in(sys_clk_in), .event_out(self_id_event_in),
    .header_out(iso_header_in)
  );

  // verdict and end of run, shared by main sequence and watchdog
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // register word comparison
  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single flag comparison
  task automatic check1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // one-cycle read strobe; data only in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a,
                            input logic [31:0] exp);
    reg_read(a, rd_val);
    check32(what, exp, rd_val);
  endtask

  // decision pulse lands in the cycle after the header
  task automatic expect_iso(input logic [5:0] ch, input logic acc);
    src.send_header(ch);
    #1;
    check1("iso_accept", acc, iso_accept_out);
    check1("iso_drop", !acc, iso_drop_out);
  endtask

  // expected tally word, unused bits zero
  function automatic logic [31:0] tally(input logic f, input logic [7:0] g,
                                        input logic [8:0] c);
    return {f, 7'h00, g, 5'h00, c, 2'h0};
  endfunction

  // tally read against its expected fields, whole word compared
  task automatic expect_tally(input string what, input logic f,
                              input logic [7:0] g, input logic [8:0] c);
    expect_reg(what, selfid_pkg::TALLY_OFFSET, tally(f, g, c));
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // reset contents, unmapped read, read data idle afterwards
    expect_tally("tally_reset", 1'b0, 8'h00, 9'h000);
    mask_exp = selfid_pkg::MASK_RESET;
    expect_reg("mask_reset", selfid_pkg::MASK_SET_OFFSET, mask_exp);
    expect_reg("unmapped", 8'h3C, 32'h0000_0000);
    @(posedge sys_clk_in);
    #1 check32("rdata_idle", 32'h0000_0000, reg_rdata_out);
    // set and clear addresses, zeros leave bits alone
    mask_exp = 32'hA5A5_0F0F;
    reg_write(selfid_pkg::MASK_SET_OFFSET, mask_exp);
    expect_reg("mask_set", selfid_pkg::MASK_SET_OFFSET, mask_exp);
    expect_reg("mask_clr", selfid_pkg::MASK_CLEAR_OFFSET, mask_exp);
    reg_write(selfid_pkg::MASK_CLEAR_OFFSET, 32'h8000_0F01);
    mask_exp = 32'h25A5_000E;
    reg_write(selfid_pkg::MASK_SET_OFFSET, 32'h0000_0000);
    reg_write(selfid_pkg::MASK_CLEAR_OFFSET, 32'h0000_0000);
    expect_reg("mask_held", selfid_pkg::MASK_CLEAR_OFFSET, mask_exp);
    // read-only tally and unmapped place ignore writes
    reg_write(selfid_pkg::TALLY_OFFSET, 32'hFFFF_FFFF);
    reg_write(8'h3C, 32'hFFFF_FFFF);
    expect_reg("tally_ro", selfid_pkg::TALLY_OFFSET, 32'h0000_0000);
    // every upper channel against its mask bit, plus a low channel
    for (int ch = 32; ch < 64; ch++) begin
      expect_iso(6'(ch), mask_exp[ch - 32]);
    end
    expect_iso(6'h05, 1'b1);
    // drop event: sticky status, masking, clearing
    check1("irq_masked", 1'b0, irq_out);
    expect_reg("irq_status", selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_0008);
    reg_write(selfid_pkg::IRQ_MASK_OFFSET, 32'h0000_0008);
    #1 check1("irq_on", 1'b1, irq_out);
    reg_write(selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_0008);
    #1 check1("irq_cleared", 1'b0, irq_out);
    expect_iso(6'h20, 1'b0);
    @(posedge sys_clk_in);
    #1 check1("irq_again", 1'b1, irq_out);
    reg_write(selfid_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
    #1 check1("irq_mask_off", 1'b0, irq_out);
    reg_write(selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_000F);
    // receptions: clean with header plus two self-id quadlets, then write error, clean, hardware error, empty
    src.bus_reset();
    gen_exp++;
    src.reception(3, -1, 1'b0);
    expect_tally("tally_ok", 1'b0, gen_exp, 9'h003);
    src.reception(2, 1, 1'b0);
    expect_tally("tally_wr_err", 1'b1, gen_exp, 9'h002);
    src.reception(4, -1, 1'b0);
    expect_tally("tally_clear", 1'b0, gen_exp, 9'h004);
    src.reception(1, 0, 1'b1);
    expect_tally("tally_hw_err", 1'b1, gen_exp, 9'h001);
    src.reception(0, -1, 1'b0);
    expect_tally("tally_restart", 1'b0, gen_exp, 9'h000);
    // self-id events in the status register
    expect_reg("irq_sid", selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_0007);
    reg_write(selfid_pkg::IRQ_MASK_OFFSET, 32'h0000_0004);
    #1 check1("irq_fault", 1'b1, irq_out);
    reg_write(selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_0007);
    expect_reg("irq_none", selfid_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
    check1("irq_idle", 1'b0, irq_out);
    // generation up to 255, then wrap
    while (gen_exp != 8'hFF) begin
      src.bus_reset();
      gen_exp++;
    end
    expect_tally("gen_top", 1'b0, 8'hFF, 9'h000);
    src.bus_reset();
    expect_tally("gen_wrap", 1'b0, 8'h00, 9'h000);
    test_done();
  end
endmodule
